/* rtl/ise_bank.sv */
`timescale 1ns/1ps
`include "ise_regs.svh"

// Operation
// R1: Bit 5 of the first enable register lets a converter PLL lock loss raise an interrupt.
// R2: Bit 4 of the first enable register lets the converter PLL gaining lock raise an interrupt.
// R3: Bit 3 of the first enable register lets a link PLL lock loss raise an interrupt.
// R4: Bit 2 of the first enable register lets the link PLL gaining lock raise an interrupt.
// R5: Any lane FIFO going full or empty is a lane error, reported when bit 1 is set; the code counts it only while link_enable is high.
// R6: A lane error stays until the link is disabled and enabled again; the code clears it as soon as the link is disabled or bit 1 is cleared.
// R7: Per-lane full status reads at 0x30c and per-lane empty status at 0x30d.
// R8: Bit 3 of the second enable register gates pattern errors on pair B imaginary.
// R9: Bit 2 of the second enable register gates pattern errors on pair B real.
// R10: Bits 1 and 0 of the second enable register gate pair A imaginary and real errors.
// R11: A disabled source never raises the request, and all enables reset to zero.
// R12: The request is the OR of every latched event whose enable is set.
module ise_bank (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire ise_pkg::ise_addr_t reg_addr,
  input wire ise_pkg::ise_byte_t reg_wdata,
  output ise_pkg::ise_byte_t reg_rdata_ff,
  // PLL lock levels, asynchronous
  input wire logic conv_pll_lock_flag,
  input wire logic link_pll_lock_flag,
  // Link and lane state, core clock
  input wire logic link_enable,
  input wire logic [7:0] lane_fifo_full,
  input wire logic [7:0] lane_fifo_empty,
  input wire logic [3:0] pattern_err,
  // Interrupt request
  output logic irq_ff
);

  ise_pkg::ise_byte_t en0_ff;
  ise_pkg::ise_byte_t nxt_en0;
  logic [3:0] en1_ff;
  logic [3:0] nxt_en1;
  ise_pkg::ise_evt_s evt_ff;
  ise_pkg::ise_evt_s nxt_evt;
  ise_pkg::ise_evt_s raw;
  ise_pkg::ise_evt_s mask;
  ise_pkg::ise_evt_s hold;
  logic [7:0] full_ff;
  logic [7:0] nxt_full;
  logic [7:0] empty_ff;
  logic [7:0] nxt_empty;
  logic [1:0] lock_st;
  logic [1:0] lock_prev_ff;
  ise_pkg::ise_byte_t nxt_rdata;
  logic nxt_irq;

  // Enable registers mapped onto the event layout
  function automatic ise_pkg::ise_evt_s ise_mask(input logic [7:0] e0, input logic [3:0] e1);
    ise_pkg::ise_evt_s m;
    m.conv_loss = e0[`ISE_CONV_LOSS_BIT];
    m.conv_lock = e0[`ISE_CONV_LOCK_BIT];
    m.link_loss = e0[`ISE_LINK_LOSS_BIT];
    m.link_lock = e0[`ISE_LINK_LOCK_BIT];
    m.lane_err = e0[`ISE_LANE_ERR_BIT];
    m.pattern[3] = e1[`ISE_PAT_B_IMAG_BIT];
    m.pattern[2] = e1[`ISE_PAT_B_REAL_BIT];
    m.pattern[1] = e1[`ISE_PAT_A_IMAG_BIT];
    m.pattern[0] = e1[`ISE_PAT_A_REAL_BIT];
    return m;
  endfunction

  // Lock flags come from PLLs running on other clocks
  ise_sync u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in({link_pll_lock_flag, conv_pll_lock_flag}),
    .level_ff(lock_st)
  );

  always_comb
  begin
    nxt_en0 = en0_ff;
    nxt_en1 = en1_ff;
    if (reg_wr && reg_addr == `ISE_EN0_ADDR)
    begin
      nxt_en0 = reg_wdata;
    end
    if (reg_wr && reg_addr == `ISE_EN1_ADDR)
    begin
      nxt_en1 = reg_wdata[3:0];
    end
  end

  always_comb
  begin
    mask = ise_mask(en0_ff, en1_ff);
    raw.conv_loss = lock_prev_ff[0] & ~lock_st[0]; // R1
    raw.conv_lock = ~lock_prev_ff[0] & lock_st[0]; // R2
    raw.link_loss = lock_prev_ff[1] & ~lock_st[1]; // R3
    raw.link_lock = ~lock_prev_ff[1] & lock_st[1]; // R4
    raw.lane_err = link_enable & ((|lane_fifo_full) | (|lane_fifo_empty)); // R5
    raw.pattern = pattern_err; // R8 R9 R10
    hold = '1;
    // Lane error drops while the link is down or while its enable bit is clear
    hold.lane_err = link_enable; // R6
    // New events win over the clear; disabled sources never latch
    nxt_evt = (evt_ff & mask & hold) | (raw & mask); // R11
    nxt_irq = |nxt_evt; // R12
  end

  // Sticky per-lane status, cleared by taking the link down
  always_comb
  begin
    nxt_full = link_enable ? (full_ff | lane_fifo_full) : `ISE_LANE_RST; // R7
    nxt_empty = link_enable ? (empty_ff | lane_fifo_empty) : `ISE_LANE_RST; // R7
  end

  // Unmapped reads return zero; upper bits of the second enable read as zero
  always_comb
  begin
    nxt_rdata = reg_rdata_ff;
    if (reg_rd)
    begin
      unique case (reg_addr)
        `ISE_EN0_ADDR: nxt_rdata = en0_ff;
        `ISE_EN1_ADDR: nxt_rdata = {4'h0, en1_ff};
        `ISE_FULL_ADDR: nxt_rdata = full_ff; // R7
        `ISE_EMPTY_ADDR: nxt_rdata = empty_ff; // R7
        default: nxt_rdata = `ISE_RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      en0_ff <= `ISE_EN0_RST; // R11
      en1_ff <= `ISE_EN1_RST; // R11
      evt_ff <= '0;
      full_ff <= `ISE_LANE_RST;
      empty_ff <= `ISE_LANE_RST;
      lock_prev_ff <= 2'h0;
      reg_rdata_ff <= `ISE_RDATA_RST;
      irq_ff <= 1'b0;
    end
    else
    begin
      en0_ff <= nxt_en0;
      en1_ff <= nxt_en1;
      evt_ff <= nxt_evt;
      full_ff <= nxt_full;
      empty_ff <= nxt_empty;
      lock_prev_ff <= lock_st;
      reg_rdata_ff <= nxt_rdata;
      irq_ff <= nxt_irq;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence s_conv_drop;
    lock_prev_ff[0] && !lock_st[0] && en0_ff[`ISE_CONV_LOSS_BIT] && !reg_wr;
  endsequence

  sequence s_conv_gain;
    !lock_prev_ff[0] && lock_st[0] && en0_ff[`ISE_CONV_LOCK_BIT] && !reg_wr;
  endsequence

  sequence s_link_drop;
    lock_prev_ff[1] && !lock_st[1] && en0_ff[`ISE_LINK_LOSS_BIT] && !reg_wr;
  endsequence

  sequence s_link_gain;
    !lock_prev_ff[1] && lock_st[1] && en0_ff[`ISE_LINK_LOCK_BIT] && !reg_wr;
  endsequence

  a_conv_loss_irq: assert property (s_conv_drop |=> evt_ff.conv_loss && irq_ff) // R1
    else $error("converter PLL loss not latched");
  a_conv_lock_irq: assert property (s_conv_gain |=> evt_ff.conv_lock && irq_ff) // R2
    else $error("converter PLL lock not latched");
  a_link_loss_irq: assert property (s_link_drop |=> evt_ff.link_loss && irq_ff) // R3
    else $error("link PLL loss not latched");
  a_link_lock_irq: assert property (s_link_gain |=> evt_ff.link_lock && irq_ff) // R4
    else $error("link PLL lock not latched");
  a_lane_err_set: assert property (link_enable && (|lane_fifo_empty) // R5
    && en0_ff[`ISE_LANE_ERR_BIT] && !reg_wr |=> evt_ff.lane_err)
    else $error("lane error not latched");
  a_lane_err_hold: assert property (evt_ff.lane_err && link_enable // R6
    && en0_ff[`ISE_LANE_ERR_BIT] && !reg_wr |=> evt_ff.lane_err
    ##1 (evt_ff.lane_err || !$past(link_enable)
    || $past(reg_wr)))
    else $error("lane error dropped while link up");
  a_lane_err_clear: assert property (!link_enable |=> !evt_ff.lane_err && full_ff == 8'h00) // R6
    else $error("lane error kept with link down");
  a_full_readback: assert property (reg_rd && reg_addr == `ISE_FULL_ADDR // R7
    |=> reg_rdata_ff == $past(full_ff))
    else $error("full status readback wrong");
  a_pat_b_gate: assert property (pattern_err[3] && en1_ff[`ISE_PAT_B_IMAG_BIT] && !reg_wr // R8
    |=> evt_ff.pattern[3])
    else $error("pair B imaginary error not latched");
  a_pat_real_gate: assert property (pattern_err[2] && !en1_ff[`ISE_PAT_B_REAL_BIT] // R9
    && !evt_ff.pattern[2] |=> !evt_ff.pattern[2])
    else $error("disabled pair B real error latched");
  a_pat_a_gate: assert property (pattern_err[1:0] == 2'h3 && en1_ff[1:0] == 2'h3 // R10
    && !reg_wr |=> evt_ff.pattern[1:0] == 2'h3 && irq_ff)
    else $error("pair A error not latched");
  a_masked_quiet: assert property (en0_ff == 8'h00 && en1_ff == 4'h0 && !reg_wr // R11
    |=> !irq_ff)
    else $error("request raised with all sources disabled");
  a_irq_or: assert property (irq_ff == (|evt_ff)) // R12
    else $error("request differs from OR of latched events");
  a_empty_readback: assert property (reg_rd && reg_addr == `ISE_EMPTY_ADDR // R7
    |=> reg_rdata_ff == $past(empty_ff))
    else $error("empty status readback wrong");
  // Read data only moves on a read, so software may sample it late
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata_ff)) // R7
    else $error("read data changed without a read");
  a_lane_err_masked: assert property (!en0_ff[`ISE_LANE_ERR_BIT] && !evt_ff.lane_err // R11
    |=> !evt_ff.lane_err)
    else $error("disabled lane error latched");

endmodule

/* rtl/ise_regs.svh */
`ifndef ISE_REGS_SVH
`define ISE_REGS_SVH

// Register offsets
`define ISE_EN0_ADDR 12'h01f
`define ISE_EN1_ADDR 12'h020
`define ISE_FULL_ADDR 12'h30c
`define ISE_EMPTY_ADDR 12'h30d

// Enable fields of the first enable register
`define ISE_CONV_LOSS_BIT 5
`define ISE_CONV_LOCK_BIT 4
`define ISE_LINK_LOSS_BIT 3
`define ISE_LINK_LOCK_BIT 2
`define ISE_LANE_ERR_BIT 1

// Enable fields of the second enable register
`define ISE_PAT_B_IMAG_BIT 3
`define ISE_PAT_B_REAL_BIT 2
`define ISE_PAT_A_IMAG_BIT 1
`define ISE_PAT_A_REAL_BIT 0

// Reset values
`define ISE_EN0_RST 8'h00
`define ISE_EN1_RST 4'h0
`define ISE_LANE_RST 8'h00
`define ISE_RDATA_RST 8'h00

`endif

/* rtl/ise_pkg.sv */
package ise_pkg;

  // One bit per interrupt source; pattern index 3..0 = b_imag, b_real, a_imag, a_real
  typedef struct packed {
    logic conv_loss;
    logic conv_lock;
    logic link_loss;
    logic link_lock;
    logic lane_err;
    logic [3:0] pattern;
  } ise_evt_s;

  typedef logic [7:0] ise_byte_t;
  typedef logic [11:0] ise_addr_t;

endpackage

/* rtl/ise_sync.sv */
`timescale 1ns/1ps

module ise_sync (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Asynchronous levels
  input wire logic [1:0] async_in,
  // Filtered levels
  output logic [1:0] level_ff
);

  logic [1:0] s1_ff;
  logic [1:0] s2_ff;
  logic [1:0] s3_ff;
  logic [1:0] nxt_level;

  // A change counts only once the second and third stages agree
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      nxt_level[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : level_ff[i];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s1_ff <= 2'h0;
      s2_ff <= 2'h0;
      s3_ff <= 2'h0;
      level_ff <= 2'h0;
    end
    else
    begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      level_ff <= nxt_level;
    end
  end

endmodule

/* bench/ise_bank_tb_top.sv */
`timescale 1ns/1ps
`include "ise_regs.svh"

module ise_bank_tb_top;
  logic ref_clk;
  logic rst;
  logic reg_wr;
  logic reg_rd;
  logic link_enable;
  logic conv_pll_lock_flag;
  logic link_pll_lock_flag;
  ise_pkg::ise_addr_t reg_addr;
  ise_pkg::ise_byte_t reg_wdata;
  ise_pkg::ise_byte_t reg_rdata_ff;
  logic [7:0] lane_fifo_full;
  logic [7:0] lane_fifo_empty;
  logic [3:0] pattern_err;
  logic irq_ff;
  int n_fail;
  int tests_run;

  ise_bank dut (
    .ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
    .conv_pll_lock_flag(conv_pll_lock_flag), .link_pll_lock_flag(link_pll_lock_flag),
    .link_enable(link_enable), .lane_fifo_full(lane_fifo_full),
    .lane_fifo_empty(lane_fifo_empty), .pattern_err(pattern_err), .irq_ff(irq_ff)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Inputs move 1 ns after the edge so sampling never races
  task automatic cyc();
    @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc();
    reg_wr = 1'b0;
    // Idle edge so a following access never re-raises the strobe in the same step
    cyc();
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    cyc();
    reg_rd = 1'b0;
    chk("rdata", exp, reg_rdata_ff);
    cyc();
  endtask

  task automatic irq_is(input logic exp);
    chk("irq", {7'h00, exp}, {7'h00, irq_ff});
  endtask

  task automatic t_regs();
    irq_is(1'b0);
    rd(`ISE_EN0_ADDR, 8'h00);
    rd(`ISE_EN1_ADDR, 8'h00);
    wr(`ISE_EN0_ADDR, 8'hff);
    rd(`ISE_EN0_ADDR, 8'hff);
    wr(`ISE_EN1_ADDR, 8'hff);
    rd(`ISE_EN1_ADDR, 8'h0f);
    rd(12'h123, 8'h00);
    wr(`ISE_FULL_ADDR, 8'hff);
    rd(`ISE_FULL_ADDR, 8'h00);
    wr(`ISE_EN0_ADDR, 8'h00);
    wr(`ISE_EN1_ADDR, 8'h00);
  endtask

  // A pulse while disabled must be dropped, not held for later
  task automatic t_pattern();
    for (int i = 0; i < 4; i++)
    begin
      pattern_err = 4'h1 << i;
      cyc();
      pattern_err = 4'h0;
      wr(`ISE_EN1_ADDR, 8'h01 << i);
      cyc();
      irq_is(1'b0);
      pattern_err = 4'h1 << i;
      cyc();
      pattern_err = 4'h0;
      irq_is(1'b1);
      wr(`ISE_EN1_ADDR, 8'h00);
      cyc();
      irq_is(1'b0);
    end
  endtask

  task automatic t_lane();
    wr(`ISE_EN0_ADDR, 8'h02);
    link_enable = 1'b1;
    lane_fifo_full = 8'h04;
    cyc();
    lane_fifo_full = 8'h00;
    cyc();
    irq_is(1'b1);
    rd(`ISE_FULL_ADDR, 8'h04);
    rd(`ISE_EMPTY_ADDR, 8'h00);
    irq_is(1'b1);
    link_enable = 1'b0;
    cyc();
    cyc();
    irq_is(1'b0);
    rd(`ISE_FULL_ADDR, 8'h00);
    link_enable = 1'b1;
    lane_fifo_empty = 8'h80;
    cyc();
    lane_fifo_empty = 8'h00;
    cyc();
    rd(`ISE_EMPTY_ADDR, 8'h80);
    link_enable = 1'b0;
    wr(`ISE_EN0_ADDR, 8'h00);
  endtask

  // Lock flags pass a synchroniser, so the wait is bounded, not fixed
  task automatic lock_case(input int b, input logic lnk, input logic lvl);
    int k;
    k = 0;
    wr(`ISE_EN0_ADDR, 8'h01 << b);
    if (lnk)
      link_pll_lock_flag = lvl;
    else
      conv_pll_lock_flag = lvl;
    while (irq_ff !== 1'b1 && k < 10)
    begin
      cyc();
      k++;
    end
    irq_is(1'b1);
    wr(`ISE_EN0_ADDR, 8'h00);
    cyc();
    irq_is(1'b0);
  endtask

  task automatic complete_run();
    $display("Checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #20000;
    n_fail++;
    complete_run();
  end

  initial
  begin
    n_fail = 0;
    tests_run = 0;
    rst = 1'b1;
    {reg_wr, reg_rd, link_enable, conv_pll_lock_flag, link_pll_lock_flag} = 5'h00;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    lane_fifo_full = 8'h00;
    lane_fifo_empty = 8'h00;
    pattern_err = 4'h0;
    repeat (10) cyc();
    rst = 1'b0;
    t_regs();
    t_pattern();
    t_lane();
    lock_case(`ISE_CONV_LOCK_BIT, 1'b0, 1'b1);
    lock_case(`ISE_CONV_LOSS_BIT, 1'b0, 1'b0);
    lock_case(`ISE_LINK_LOCK_BIT, 1'b1, 1'b1);
    lock_case(`ISE_LINK_LOSS_BIT, 1'b1, 1'b0);
    complete_run();
  end
endmodule
